/* File: swap_xor_direction_ops_tb_top.sv */
// Self-checking bench for the execution block.
// Assumes sxd_exec and its checker are compiled first.
`timescale 1ns/1ps
`include "sxd_defs.vh"
module swap_xor_direction_ops_tb_top;
   logic       ref_clk = 0, sys_rst = 1, op_valid = 0, u = 0, t = 0;
   logic [1:0] op_code = 0;
   logic [6:0] a = 0;
   logic [7:0] k = 0, d = 0;
   wire        we, z;
   wire  [6:0] wa;
   wire  [7:0] wd, acc, pa, pb, pc;
   int         mismatches = 0, n_tests = 0, cyc = 0;
   // Row: op, literal select, literal, file data, accumulator, flag.
   logic [27:0] rows [6] = '{{`SXD_OP_XOR, 1'h1, 8'hA5, 8'h00, 8'hA5, 1'h0},
      {`SXD_OP_XOR, 1'h1, 8'hA5, 8'h00, 8'h00, 1'h1},
      {`SXD_OP_XOR, 1'h0, 8'h00, 8'h3C, 8'h3C, 1'h0},
      {`SXD_OP_SWAP, 1'h0, 8'h00, 8'h12, 8'h21, 1'h0},
      {`SXD_OP_XOR, 1'h0, 8'h00, 8'h21, 8'h00, 1'h1},
      {`SXD_OP_SWAP, 1'h0, 8'h00, 8'hF0, 8'h0F, 1'h1}};
   sxd_exec i_dut (.ref_clk, .sys_rst, .op_valid, .op_code, .use_literal(u),
      .result_target_bit(t), .file_addr(a), .literal_val(k),
      .file_rd_data(d), .file_wr_en(we), .file_wr_addr(wa),
      .file_wr_data(wd), .acc_out(acc), .all_clear_flag(z),
      .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc));
   always #2.5 ref_clk = ~ref_clk;
   // The strobe stays high across back-to-back calls, so it is never set
   // twice in one time step; the caller lowers it when the ops run out.
   task run(input [1:0] o, input lu, lt, input [6:0] la, input [7:0] lk, ld);
      {op_code, u, t, a, k, d} = {o, lu, lt, la, lk, ld};
      op_valid = 1;
      @(posedge ref_clk);
      #1;
   endtask
   task chk(input string n, input [15:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test;
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 200)
      begin
         mismatches++;
         end_of_test;
      end
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      #1 sys_rst = 0;
      chk("dir_c", 8'hFF, pc);
      foreach (rows[i])
      begin
         run(rows[i][27:26], rows[i][25], 0, 7'h10, rows[i][24:17],
            rows[i][16:9]);
         chk("acc", rows[i][8:1], acc);
         chk("flag", {7'h0, rows[i][0]}, {7'h0, z});
      end
      // Accumulator changes between loads so a wrong select shows.
      for (int p = 5; p < 8; p++)
      begin
         run(`SXD_OP_DIR, 0, 0, p[6:0], 0, 0);
         run(`SXD_OP_XOR, 1, 0, 0, p[7:0], 0);
      end
      run(`SXD_OP_DIR, 0, 0, 7'h04, 0, 0);
      chk("dir_a", 8'h0F, pa);
      chk("dir_b", 8'h0A, pb);
      chk("dir_c", 8'h0C, pc);
      run(`SXD_OP_SWAP, 0, 1, 7'h7F, 0, 8'hA5);
      chk("wr", {1'h1, 7'h7F, 8'h5A}, {we, wa, wd});
      chk("acc", 8'h0B, acc);
      run(`SXD_OP_XOR, 0, 1, 7'h00, 0, 8'h0B);
      chk("wr", {1'h1, 7'h00, 8'h00}, {we, wa, wd});
      chk("flag", 8'h01, {7'h0, z});
      run(`SXD_OP_XOR, 1, 1, 0, 8'h0B, 0);
      chk("acc", {1'h0, 8'h00}, {we, acc});
      run(`SXD_OP_SWAP, 0, 0, 7'h01, 0, 8'h96);
      chk("acc", {8'h69, 8'h01}, {acc, 7'h0, z});
      // Reset in mid-run must clear everything the earlier ops left.
      op_valid = 0;
      sys_rst = 1;
      repeat (2) @(posedge ref_clk);
      #1 sys_rst = 0;
      chk("rst_acc", 8'h00, acc);
      chk("rst_flag", 8'h00, {7'h0, z});
      chk("rst_dir", 16'hFFFF, {pa, pb});
      chk("rst_dir_c", 8'hFF, pc);
      // First op on the first edge after release; a swap still writes
      // the file although use_literal is high.
      run(`SXD_OP_SWAP, 1, 1, 7'h40, 8'hFF, 8'h3C);
      chk("wr", {1'h1, 7'h40, 8'hC3}, {we, wa, wd});
      chk("acc", 8'h00, acc);
      run(`SXD_OP_NONE, 0, 1, 7'h05, 8'hFF, 8'hFF);
      chk("acc", {1'h0, 8'h00}, {we, acc});
      chk("dir_a", 8'hFF, pa);
      op_valid = 0;
      end_of_test;
   end
endmodule

/* File: sxd_defs.vh */
// Constants for the swap, exclusive OR and direction load execution block.
// Assumes inclusion by the design, checker and bench files of this block.
`ifndef SXD_DEFS_VH
`define SXD_DEFS_VH

// ----------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------
`define SXD_OP_W           2
`define SXD_OP_NONE        2'h0
`define SXD_OP_SWAP        2'h1
`define SXD_OP_DIR         2'h2
`define SXD_OP_XOR         2'h3

// ----------------------------------------------------------------------
// Operand selectors and fields
// ----------------------------------------------------------------------
`define SXD_DIR_SEL_A      7'h05
`define SXD_DIR_SEL_B      7'h06
`define SXD_DIR_SEL_C      7'h07
`define SXD_NIB_HI_MSB     7
`define SXD_NIB_HI_LSB     4
`define SXD_NIB_LO_MSB     3
`define SXD_NIB_LO_LSB     0
`define SXD_DEST_ACC       1'h0
`define SXD_DEST_FILE      1'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SXD_ACC_RST        8'h00
`define SXD_DIR_RST        8'hFF
`define SXD_FLAG_RST       1'h0

`endif

/* File: sxd_exec.v */
// Execution block for nibble swap, direction load and exclusive OR.
// Assumes the core supplies decoded operations and file read data in the
// same cycle, and writes back file data from file_wr_en/file_wr_data.
//
// What this block does
// RULE_01: Swap moves file bits 3:0 to 7:4 and 7:4 to 3:0, flags unchanged.
// RULE_02: Swap result goes to the accumulator for target 0, the file for 1.
// RULE_03: Direction load copies acc to port A, B, C for 5, 6, 7, no flags.
// RULE_04: Literal xor puts acc xor literal in acc, only all clear updates.
// RULE_05: File xor combines acc with file 0 to 127, only all clear updates.
// RULE_06: File xor result goes to the accumulator for target 0, file for 1.
// RULE_07: All clear is set when the xor result is zero, cleared otherwise.
`timescale 1ns/1ps
`include "sxd_defs.vh"

module sxd_exec
(
   ref_clk,
   sys_rst,
   op_valid,
   op_code,
   use_literal,
   result_target_bit,
   file_addr,
   literal_val,
   file_rd_data,
   file_wr_en,
   file_wr_addr,
   file_wr_data,
   acc_out,
   all_clear_flag,
   port_a_direction,
   port_b_direction,
   port_c_direction
);
   input  wire                 ref_clk;
   input  wire                 sys_rst;
   input  wire                 op_valid;
   input  wire [`SXD_OP_W-1:0] op_code;
   input  wire                 use_literal;
   input  wire                 result_target_bit;
   input  wire [6:0]           file_addr;
   input  wire [7:0]           literal_val;
   input  wire [7:0]           file_rd_data;
   output reg                  file_wr_en;
   output reg  [6:0]           file_wr_addr;
   output reg  [7:0]           file_wr_data;
   output wire [7:0]           acc_out;
   output wire                 all_clear_flag;
   output wire [7:0]           port_a_direction;
   output wire [7:0]           port_b_direction;
   output wire [7:0]           port_c_direction;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg  [7:0]           acc_reg;
   reg  [7:0]           acc_next;
   reg                  zero_reg;
   reg                  zero_next;
   reg                  wr_en_next;
   wire [2:0]           dir_hit;
   wire [23:0]          dir_all;
   wire [`SXD_OP_W-1:0] unit_op;
   wire [7:0]           result;
   wire                 result_zero;
   wire                 is_swap;
   wire                 is_dir;
   wire                 is_xor;
   wire                 to_file;

   // -------------------------------------------------------------------
   // Decoding
   // -------------------------------------------------------------------
   // One shared decode keeps an idle op_valid from starting anything,
   // whatever op_code happens to hold in that cycle.
   function op_match;
      input                 valid;
      input [`SXD_OP_W-1:0] code;
      input [`SXD_OP_W-1:0] want;
      begin
         op_match = valid && (code == want);
      end
   endfunction

   // Operands outside 5 to 7 select nothing, so a stray load is dropped.
   function [2:0] dir_select;
      input [6:0] addr;
      begin
         case (addr)
            `SXD_DIR_SEL_A:
               dir_select = 3'h1;
            `SXD_DIR_SEL_B:
               dir_select = 3'h2;
            `SXD_DIR_SEL_C:
               dir_select = 3'h4;
            default:
               dir_select = 3'h0;
         endcase
      end
   endfunction

   assign is_swap = op_match(op_valid, op_code, `SXD_OP_SWAP);
   assign is_dir  = op_match(op_valid, op_code, `SXD_OP_DIR);
   assign is_xor  = op_match(op_valid, op_code, `SXD_OP_XOR);
   assign dir_hit = dir_select(file_addr);
   assign unit_op = op_valid ? op_code : `SXD_OP_NONE;
   // Only the literal exclusive OR ignores the target bit; a swap honours
   // it even when use_literal is left high by the decoder.
   assign to_file = (result_target_bit == `SXD_DEST_FILE) &&
                    !(is_xor && use_literal);

   // -------------------------------------------------------------------
   // Result unit
   // -------------------------------------------------------------------
   sxd_logic_unit u_logic
   (
      .op          (unit_op),
      .acc         (acc_reg),
      .file_data   (file_rd_data),
      .literal_val (literal_val),
      .use_literal (use_literal),
      .result      (result),
      .result_zero (result_zero)
   );

   // -------------------------------------------------------------------
   // Accumulator
   // -------------------------------------------------------------------
   always @*
   begin
      acc_next = acc_reg;
      if ((is_swap || is_xor) && !to_file)
      begin
         acc_next = result; // RULE_02 RULE_06
      end
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         acc_reg <= `SXD_ACC_RST;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   // -------------------------------------------------------------------
   // All clear flag
   // -------------------------------------------------------------------
   // Swap and direction load leave the flag alone; only the exclusive OR
   // forms write it.
   always @*
   begin
      zero_next = zero_reg;
      if (is_xor)
      begin
         zero_next = result_zero; // RULE_04 RULE_05 RULE_07
      end
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         zero_reg <= `SXD_FLAG_RST;
      end
      else
      begin
         zero_reg <= zero_next;
      end
   end

   // -------------------------------------------------------------------
   // File write-back
   // -------------------------------------------------------------------
   // The strobe lasts one cycle; address and data follow every cycle so
   // the register file sees them settled together with the strobe.
   always @*
   begin
      wr_en_next = (is_swap || is_xor) && to_file; // RULE_02 RULE_06
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         file_wr_en   <= 1'h0;
         file_wr_addr <= 7'h00;
         file_wr_data <= 8'h00;
      end
      else
      begin
         file_wr_en   <= wr_en_next;
         file_wr_addr <= file_addr;
         file_wr_data <= result;
      end
   end

   // -------------------------------------------------------------------
   // Direction registers
   // -------------------------------------------------------------------
   // Directions reset to all ones so every port starts as an input.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_dir
         reg [7:0] dir_reg;

         always @(posedge ref_clk)
         begin
            if (sys_rst)
            begin
               dir_reg <= `SXD_DIR_RST;
            end
            else if (is_dir && dir_hit[g])
            begin
               dir_reg <= acc_reg; // RULE_03
            end
         end

         assign dir_all[8*g+7:8*g] = dir_reg;
      end
   endgenerate

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign acc_out          = acc_reg;
   assign all_clear_flag   = zero_reg;
   assign port_a_direction = dir_all[7:0];
   assign port_b_direction = dir_all[15:8];
   assign port_c_direction = dir_all[23:16];
endmodule

/* File: sxd_exec_chk.sv */
// Port assertions for the execution block.
// Assumes it is bound onto sxd_exec, which has one clock.
`timescale 1ns/1ps
`include "sxd_defs.vh"
module sxd_exec_chk
(
   input logic       ref_clk,
   input logic       sys_rst,
   input logic       op_valid,
   input logic [1:0] op_code,
   input logic       use_literal,
   input logic       result_target_bit,
   input logic [6:0] file_addr,
   input logic [7:0] literal_val,
   input logic [7:0] file_rd_data,
   input logic       file_wr_en,
   input logic [6:0] file_wr_addr,
   input logic [7:0] file_wr_data,
   input logic [7:0] acc_out,
   input logic       all_clear_flag,
   input logic [7:0] port_a_direction,
   input logic [7:0] port_b_direction,
   input logic [7:0] port_c_direction
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire sw = op_valid && op_code == `SXD_OP_SWAP;
   wire dl = op_valid && op_code == `SXD_OP_DIR;
   wire xo = op_valid && op_code == `SXD_OP_XOR;
   wire xf = xo && !use_literal;
   wire db = dl && file_addr == `SXD_DIR_SEL_B;
   wire dc = dl && file_addr == `SXD_DIR_SEL_C;
   wire dn = dl && (file_addr < `SXD_DIR_SEL_A || file_addr > `SXD_DIR_SEL_C);
   wire [7:0] x = acc_out ^ (use_literal ? literal_val : file_rd_data);
   wire [7:0] s = {file_rd_data[3:0], file_rd_data[7:4]};
   a_swap_acc: assert property (sw && !result_target_bit |=>
      acc_out == $past(s)) else $error("swap to acc");
   a_swap_file: assert property (sw && result_target_bit |=>
      file_wr_en && file_wr_data == $past(s) && $stable(acc_out))
      else $error("swap to file");
   a_flag_kept: assert property ((sw || dl) |=>
      $stable(all_clear_flag)) else $error("flag moved");
   a_dir_load: assert property (dl && file_addr == `SXD_DIR_SEL_A |=>
      port_a_direction == $past(acc_out)) else $error("dir a");
   a_dir_load_b: assert property (db |=>
      port_b_direction == $past(acc_out)) else $error("dir b");
   a_dir_load_c: assert property (dc |=>
      port_c_direction == $past(acc_out)) else $error("dir c");
   a_dir_refused: assert property (dn |=>
      $stable(port_a_direction) && $stable(port_b_direction)
      && $stable(port_c_direction)) else $error("dir refused");
   a_xor_lit: assert property (xo && use_literal |=>
      acc_out == $past(x) && !file_wr_en) else $error("xor lit");
   a_xor_file: assert property (xf && result_target_bit |=>
      file_wr_en && file_wr_data == $past(x)
      && file_wr_addr == $past(file_addr)) else $error("xor file");
   a_xor_acc: assert property (xf && !result_target_bit |=>
      acc_out == $past(x)) else $error("xor acc");
   a_zero_flag: assert property (xo |=>
      all_clear_flag == ($past(x) == 8'h00)) else $error("zero flag");
endmodule

bind sxd_exec sxd_exec_chk u_chk (.ref_clk, .sys_rst, .op_valid, .op_code,
   .use_literal, .result_target_bit, .file_addr, .literal_val,
   .file_rd_data, .file_wr_en, .file_wr_addr, .file_wr_data, .acc_out,
   .all_clear_flag, .port_a_direction, .port_b_direction,
   .port_c_direction);

/* File: sxd_logic_unit.v */
// Combinational result unit: nibble swap and exclusive OR.
// Assumes operands are settled within the same core clock cycle.
`timescale 1ns/1ps
`include "sxd_defs.vh"

module sxd_logic_unit
(
   op,
   acc,
   file_data,
   literal_val,
   use_literal,
   result,
   result_zero
);
   input  wire [`SXD_OP_W-1:0] op;
   input  wire [7:0]           acc;
   input  wire [7:0]           file_data;
   input  wire [7:0]           literal_val;
   input  wire                 use_literal;
   output reg  [7:0]           result;
   output wire                 result_zero;

   wire [7:0] xor_src;

   assign xor_src = use_literal ? literal_val : file_data;

   always @*
   begin
      case (op)
         `SXD_OP_SWAP:
         begin
            result = {file_data[`SXD_NIB_LO_MSB:`SXD_NIB_LO_LSB],
                      file_data[`SXD_NIB_HI_MSB:`SXD_NIB_HI_LSB]}; // RULE_01
         end
         `SXD_OP_XOR:
         begin
            result = acc ^ xor_src; // RULE_04
         end
         default:
         begin
            result = acc;
         end
      endcase
   end

   assign result_zero = (result == 8'h00); // RULE_07
endmodule
